// ---- verilog/status_regs_pkg.sv ----
// package: offsets, field positions and reset values of the status group
package status_regs_pkg;
  localparam logic [5:0] ADDR_FUNCTIONAL = 6'h03; // functional_status
  localparam logic [5:0] ADDR_MEMORY = 6'h04; // one_time_memory_status
  localparam logic [5:0] ADDR_CONVERTER = 6'h05; // converter status
  localparam logic [15:0] RESET_VALUE = 16'h0000; // all three registers
  localparam logic [7:0] RSVD_HI8 = 8'h00; // reserved upper byte
  localparam logic [11:0] RSVD_HI12 = 12'h000; // reserved bits 15:4
  // sense gain codes
  localparam logic [2:0] GAIN_4 = 3'h0;
  localparam logic [2:0] GAIN_8 = 3'h1;
  localparam logic [2:0] GAIN_12 = 3'h2;
  localparam logic [2:0] GAIN_16 = 3'h3;
  localparam logic [2:0] GAIN_64 = 3'h7;
  localparam int SYNC_STAGES = 2; // flops on each pin input
endpackage

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second stage

  // plain two-stage chain; resets low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- verilog/functional_memory_converter_status_regs.sv ----
// read-only status group: hall, supply, gain, memory and converter status
// Behaviour
// - hall input levels in bits 2:0
// - bit 3 set when all halls equal
// - bit 4 logic supply setpoint, 1=5V
// - bits 7:5 report active sense gain code
// - reserved bits always read zero
// - memory bit 0 set when custom values loaded
// - memory bit 1 set on passed programming
// - memory bit 2 set when programming refused
// - memory bit 3 set when programming failed
// - converter bit 0 on-demand result ready
// - converter bits 7:1 hold latest result
`timescale 1ns/100ps
module functional_memory_converter_status_regs (
  input wire logic core_clk,
  input wire logic rstn,
  // hall comparator pins, asynchronous
  input wire logic [2:0] hall_input_levels,
  // internal status sources, already on core_clk
  input wire logic logic_supply_setpoint_flag,
  input wire logic [2:0] sense_amp_gain_code,
  input wire logic memory_custom_loaded,
  input wire logic memory_program_passed,
  input wire logic memory_program_refused,
  input wire logic memory_program_failed,
  input wire logic on_demand_result_ready,
  input wire logic [6:0] on_demand_result_value,
  // register port from the serial interface
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid
);

  logic [2:0] hall_sync; // synchronised hall levels
  logic [15:0] func_q; // functional status
  logic [15:0] func_d;
  logic [15:0] mem_q; // memory status
  logic [15:0] mem_d;
  logic [15:0] conv_q; // converter status
  logic [15:0] conv_d;
  logic [15:0] rdata_d;
  logic hall_equal; // all three equal
  logic hit_func;
  logic hit_mem;
  logic hit_conv;

  // pins cross into core_clk before anything looks at them
  pin_sync #(.WIDTH(3)) u_hall_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in(hall_input_levels),
    .sync_out(hall_sync)
  );

  // equal polarity: all high or all low
  assign hall_equal = (&hall_sync) | ~(|hall_sync);

  // functional image, reserved byte forced to zero
  assign func_d = {status_regs_pkg::RSVD_HI8,
                   sense_amp_gain_code,
                   logic_supply_setpoint_flag,
                   hall_equal,
                   hall_sync};

  // memory image
  assign mem_d = {status_regs_pkg::RSVD_HI12,
                  memory_program_failed,
                  memory_program_refused,
                  memory_program_passed,
                  memory_custom_loaded};

  // converter image
  assign conv_d = {status_regs_pkg::RSVD_HI8,
                   on_demand_result_value,
                   on_demand_result_ready};

  // address decode
  assign hit_func = (reg_addr == status_regs_pkg::ADDR_FUNCTIONAL);
  assign hit_mem = (reg_addr == status_regs_pkg::ADDR_MEMORY);
  assign hit_conv = (reg_addr == status_regs_pkg::ADDR_CONVERTER);

  // read mux; unmapped addresses read zero
  always_comb begin
    if (hit_func) begin
      rdata_d = func_q;
    end else if (hit_mem) begin
      rdata_d = mem_q;
    end else if (hit_conv) begin
      rdata_d = conv_q;
    end else begin
      rdata_d = status_regs_pkg::RESET_VALUE;
    end
  end

  // status images follow their sources every cycle; reg_wr and
  // reg_wdata are deliberately not used here, so writes do nothing
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      func_q <= status_regs_pkg::RESET_VALUE;
      mem_q <= status_regs_pkg::RESET_VALUE;
      conv_q <= status_regs_pkg::RESET_VALUE;
    end else begin
      func_q <= func_d;
      mem_q <= mem_d;
      conv_q <= conv_d;
    end
  end

  // read data registered, valid one cycle after the strobe; the word is
  // captured only on a strobe so it stays put for a slow serial shifter,
  // at no cost in read latency, which stays at the one cycle of the register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= status_regs_pkg::RESET_VALUE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // helper: a write with data in the cycle, for the no-effect check
  logic wr_seen;
  assign wr_seen = reg_wr & (|reg_wdata);

  // helper: high from the second edge after reset onward; at the first
  // edge the images still hold their reset value, which need not match
  // the live sources, so checks that compare with $past wait for it
  logic primed_q;

  // priming flop; constants only in the reset branch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  // helper: address of the last read strobe, for the answer checks
  logic [5:0] last_addr_q;

  // capture the address with the strobe, like the read data register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_addr_q <= '0;
    end else if (reg_rd) begin
      last_addr_q <= reg_addr;
    end
  end

  // helper: true when the last read hit none of the three registers
  logic last_unmapped;
  assign last_unmapped =
    (last_addr_q != status_regs_pkg::ADDR_FUNCTIONAL) &&
    (last_addr_q != status_regs_pkg::ADDR_MEMORY) &&
    (last_addr_q != status_regs_pkg::ADDR_CONVERTER);

  // step sequences for the read port
  // a read strobe towards the converter register
  sequence s_read_conv;
    reg_rd && hit_conv;
  endsequence

  // a read strobe towards an address outside the group
  sequence s_read_none;
    reg_rd && !hit_func && !hit_mem && !hit_conv;
  endsequence

  // the answer edge: valid raised by the read register
  sequence s_answer;
    reg_rvalid;
  endsequence

  // functional image: each hall pin lands one edge after its sync flop
  a_hall_mirror: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> func_q[2:0] == $past(hall_sync))
    else $error("hall levels not mirrored");

  // a functional read returns the image held at the strobe
  a_func_read: assert property (
    @(posedge core_clk) disable iff (!rstn)
    reg_rd && hit_func |=> reg_rdata == $past(func_q))
    else $error("functional read data wrong");

  // equal flag must agree with the levels stored beside it
  a_hall_equal: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> func_q[3] == ((&func_q[2:0]) || !(|func_q[2:0])))
    else $error("hall equal flag wrong");

  // supply setpoint copied whatever strapping chose it
  a_supply_flag: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> func_q[4] == $past(logic_supply_setpoint_flag))
    else $error("supply setpoint not reported");

  // gain code passes through untouched, undefined codes included
  a_gain_code: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> func_q[7:5] == $past(sense_amp_gain_code))
    else $error("gain code not reported");

  // reserved bits of whatever was read stay zero
  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!rstn)
    s_answer |-> (reg_rdata[15:8] == status_regs_pkg::RSVD_HI8) &&
      (last_addr_q != status_regs_pkg::ADDR_MEMORY ||
       reg_rdata[15:4] == status_regs_pkg::RSVD_HI12))
    else $error("reserved bits not zero");

  // reserved bits of the stored images stay zero at all times
  a_image_reserved: assert property (
    @(posedge core_clk) disable iff (!rstn)
    func_q[15:8] == status_regs_pkg::RSVD_HI8 &&
      conv_q[15:8] == status_regs_pkg::RSVD_HI8 &&
      mem_q[15:4] == status_regs_pkg::RSVD_HI12)
    else $error("image reserved bits not zero");

  // unmapped reads answer with an all-zero word
  a_unmapped_zero: assert property (
    @(posedge core_clk) disable iff (!rstn)
    s_read_none |=> reg_rvalid && last_unmapped &&
      reg_rdata == status_regs_pkg::RESET_VALUE)
    else $error("unmapped read not zero");

  // custom-values-loaded bit follows its source
  a_mem_loaded: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> mem_q[0] == $past(memory_custom_loaded))
    else $error("custom loaded bit wrong");

  // a memory read returns the image held at the strobe
  a_mem_read: assert property (
    @(posedge core_clk) disable iff (!rstn)
    reg_rd && hit_mem |=> reg_rdata == $past(mem_q))
    else $error("memory read data wrong");

  // passed bit only set while the source says passed
  a_mem_passed: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> mem_q[1] == $past(memory_program_passed))
    else $error("program passed bit wrong");

  // refused attempt shows in bit 2 the edge after it is reported
  a_mem_refused: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(memory_program_refused) |=> mem_q[2])
    else $error("refused bit not set");

  // refused bit also clears when its source does; no stickiness here
  a_refused_live: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> mem_q[2] == $past(memory_program_refused))
    else $error("refused bit not live");

  // failed bit mirrors its source
  a_mem_failed: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> mem_q[3] == $past(memory_program_failed))
    else $error("failed bit wrong");

  // ready bit read back is the image sampled with the strobe
  a_conv_ready: assert property (
    @(posedge core_clk) disable iff (!rstn)
    s_read_conv ##1 s_answer |-> reg_rdata[0] == $past(conv_q[0]))
    else $error("ready bit read wrong");

  // ready image follows the converter flag, low while nothing is ready
  a_ready_live: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> conv_q[0] == $past(on_demand_result_ready))
    else $error("ready image not live");

  // converter image follows the result value
  a_conv_value: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> conv_q[7:1] == $past(on_demand_result_value))
    else $error("result value wrong");

  // a write leaves all images on their source path
  a_write_ignored: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wr_seen |=> func_q == $past(func_d) && mem_q == $past(mem_d) &&
      conv_q == $past(conv_d))
    else $error("write changed status");

  // one answer per strobe, one cycle later, never unprompted
  a_read_answer: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q |-> reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after strobe");

  // read data hold their value between answers
  a_rdata_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    primed_q && !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");

endmodule

// ---- verification/status_host.sv ----
// host model: issues register reads and writes on the status port
`timescale 1ns/100ps
module status_host (
  input wire logic core_clk,
  output logic reg_rd,
  output logic reg_wr,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle strobes from time zero
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
  end
  // one-cycle read strobe; answer is taken the edge after
  task automatic read_reg(input logic [5:0] a, output logic [15:0] d,
                          output logic v);
    @(posedge core_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
  // write strobe; wdata inverted afterwards so nothing stale lingers
  task automatic write_reg(input logic [5:0] a, input logic [15:0] w);
    @(posedge core_clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = w;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~w;
  endtask
endmodule

// ---- verification/functional_memory_converter_status_regs_tb_top.sv ----
// bench: status reads compared with images built from the source levels
`timescale 1ns/100ps
module functional_memory_converter_status_regs_tb_top;
  logic core_clk = 1'b0; // 100 MHz
  logic rstn = 1'b0;
  logic [2:0] hall = 3'h0; // pin levels a, b, c
  logic sup = 1'b0;
  logic [2:0] gain = 3'h0;
  logic [3:0] mem = 4'h0; // failed, refused, passed, loaded
  logic rdy = 1'b0;
  logic [6:0] val = 7'h00;
  logic rd, wr, rvalid, v;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [2:0] gains [5] = '{status_regs_pkg::GAIN_4, status_regs_pkg::GAIN_8,
    status_regs_pkg::GAIN_12, status_regs_pkg::GAIN_16,
    status_regs_pkg::GAIN_64};
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  functional_memory_converter_status_regs dut (.core_clk(core_clk),
    .rstn(rstn), .hall_input_levels(hall), .logic_supply_setpoint_flag(sup),
    .sense_amp_gain_code(gain), .memory_custom_loaded(mem[0]),
    .memory_program_passed(mem[1]), .memory_program_refused(mem[2]),
    .memory_program_failed(mem[3]), .on_demand_result_ready(rdy),
    .on_demand_result_value(val), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid));
  status_host host (.core_clk(core_clk), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid));
  // expected image of each address from current source levels
  function automatic logic [15:0] img(input logic [5:0] a);
    case (a)
      status_regs_pkg::ADDR_FUNCTIONAL:
        return {8'h00, gain, sup, hall == 3'h0 || hall == 3'h7, hall};
      status_regs_pkg::ADDR_MEMORY: return {12'h000, mem};
      status_regs_pkg::ADDR_CONVERTER: return {8'h00, val, rdy};
      default: return 16'h0000; // unmapped reads as zero
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // read, compare data and the one-cycle valid
  task automatic rd_chk(input string what, input logic [5:0] a);
    host.read_reg(a, d, v);
    check(what, d, img(a));
    check("rvalid", {15'h0000, v}, 16'h0001);
  endtask
  // hall pins need 4 edges to reach read data; 5 leaves margin
  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask
  task automatic final_report();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rstn = 1'b1;
    for (int a = 3; a < 6; a++) begin
      rd_chk("reset", 6'(a));
    end
    // every hall pattern, supply toggling, gain codes cycling
    for (int i = 0; i < 8; i++) begin
      hall = 3'(i);
      sup = i[0];
      gain = gains[i % 5];
      settle();
      rd_chk("functional", status_regs_pkg::ADDR_FUNCTIONAL);
    end
    // all memory flag combinations
    for (int i = 0; i < 16; i++) begin
      mem = 4'(i);
      settle();
      rd_chk("memory", status_regs_pkg::ADDR_MEMORY);
    end
    for (int j = 0; j < 4; j++) begin
      rdy = j[0];
      val = 7'(j * 37 + 42);
      settle();
      rd_chk("converter", status_regs_pkg::ADDR_CONVERTER);
    end
    // writes of all ones must leave every image alone
    for (int a = 3; a < 7; a++) begin
      host.write_reg(6'(a), 16'hFFFF);
      rd_chk("after write", 6'(a));
    end
    final_report();
  end
endmodule
